// File: core/tsec_core.sv
// Task switch, exception sequencing and pointer test control core
`timescale 1ns/100ps
// Function
// - Jump, call or interrupt naming a task descriptor or gate switches tasks
// - Task selector register load also loads its hidden base and limit
// - Interrupt return pops when nested-task flag is 0, else switches back
// - Switch marks new segment busy, old unless jump, writes back link
// - Call or interrupt switch sets nested-task; plain interrupt clears it
// - Busy marking changes type 1 to 3; busy segment use gives vector 13
// - Faults map to vectors 8, 9, 10, 11, 12 and 13
// - Vectors 8, 10-13 push error code at fault; 9 does neither
// - Wrapped push-all or pop-all, saved pointer 0,1,FFFE,FFFF, not restartable
// - Task switch leaves the coprocessor context untouched
// - Every task switch sets the task-switched flag
// - Escape or wait with task-switched and coprocessor-present gives vector 7
// - Privilege adjust raises field to maximum, zero flag if changed
// - Read and write verify set zero flag, never raise an exception
// - Limit and access load copy on success and set zero flag
// - Two exceptions in one instruction give 8; another means shutdown
// - Shutdown stops switches, returns, exceptions and pointer tests; NMI exits keeping mode, reset leaves it
// - Shutdown is announced by a halt cycle with address bit 1 low
// - Code fetches drive high address bits until code segment changes or protection enable is set
// - Reset starts fetching at F000:FFF0
module tsec_core (
    // Clock and reset
    input  wire logic                   mclk_i,
    input  wire logic                   rstn_i,
    // Register port
    input  wire logic [3:0]             reg_addr_i,
    input  wire logic [15:0]            reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [15:0]            reg_rdata_o,
    // Task switch requests
    input  wire logic                   ts_req_i,
    input  wire tsec_pkg::tsec_ts_req_s ts_info_i,
    input  wire logic [23:0]            tr_desc_base_i,
    input  wire logic [15:0]            tr_desc_limit_i,
    input  wire logic                   interrupt_return_instruction_i,
    input  wire logic                   irq_nosw_i,
    output logic                        ts_act_valid_o,
    output tsec_pkg::tsec_ts_act_s      ts_act_o,
    output logic                        interrupt_return_instruction_switch_o,
    output logic                        interrupt_return_instruction_pop_o,
    // Exceptions
    input  wire logic                   exc_req_i,
    input  wire logic [7:0]             exc_vec_i,
    input  wire logic                   stack_wrap_i,
    input  wire logic [15:0]            saved_sp_i,
    input  wire logic                   esc_i,
    input  wire logic                   instr_end_i,
    input  wire logic                   nmi_i,
    output logic                        exc_valid_o,
    output tsec_pkg::tsec_exc_s         exc_o,
    output logic                        running_o,
    output logic                        halt_o,
    output logic                        a1_o,
    // Pointer tests
    input  wire logic                   ptest_req_i,
    input  wire tsec_pkg::tsec_ptest_s  ptest_i,
    output logic                        ptest_done_o,
    output logic                        ptest_zf_o,
    output logic      [15:0]            ptest_val_o,
    // Boot addressing
    input  wire tsec_pkg::tsec_seg_e    seg_ref_i,
    input  wire logic                   cs_load_i,
    output logic      [3:0]             a_hi_o,
    output logic      [15:0]            boot_cs_o,
    output logic      [15:0]            boot_ip_o
);

    typedef enum logic [1:0] {
        st_run, st_exc, st_df, st_shut
    } tsec_state_e;

    function automatic logic has_err(input logic [7:0] v);
        has_err = (v == tsec_pkg::V_DF) ||
                  (v >= tsec_pkg::V_TSS && v <= tsec_pkg::V_GP);
    endfunction

    function automatic logic sp_wrapped(input logic [15:0] sp);
        sp_wrapped = (sp == tsec_pkg::SP_WRAP_0) ||
                     (sp == tsec_pkg::SP_WRAP_1) ||
                     (sp == tsec_pkg::SP_WRAP_2) ||
                     (sp == tsec_pkg::SP_WRAP_3);
    endfunction

    function automatic logic reg_hit(input logic [3:0] a,
                                     input logic [3:0] r);
        reg_hit = (a == r);
    endfunction

    // State
    tsec_state_e state;
    tsec_state_e next_state;
    logic        msw_pe;
    logic        msw_mp;
    logic        msw_ts;
    logic        flag_nt;
    logic        cs_changed;
    logic [15:0] tr_sel;
    logic [23:0] tr_base;
    logic [15:0] tr_limit;

    // Register decode
    wire logic wr_msw   = reg_wr_i && reg_hit(reg_addr_i, tsec_pkg::REG_MSW);
    wire logic wr_flags = reg_wr_i &&
                          reg_hit(reg_addr_i, tsec_pkg::REG_FLAGS);
    wire logic wr_tr    = reg_wr_i &&
                          reg_hit(reg_addr_i, tsec_pkg::REG_TR_SEL);

    // Task switch checks
    wire logic live     = (state != st_shut);
    wire logic is_jmp   = (ts_info_i.src == tsec_pkg::src_jmp);
    wire logic ts_busy  = ts_req_i &&
                          ts_info_i.new_type == tsec_pkg::TYPE_BUSY;
    wire logic ts_badl  = ts_req_i &&
                          ts_info_i.new_limit <= tsec_pkg::TSS_MIN_LIMIT;
    wire logic ts_fault = ts_busy || ts_badl;
    wire logic ts_ok    = ts_req_i && !ts_fault && live;
    wire logic interrupt_return_instruction_back = interrupt_return_instruction_i && flag_nt && live;
    wire logic interrupt_return_instruction_pl  = interrupt_return_instruction_i && !flag_nt && live;

    // Exception candidates
    wire logic cop_fault = esc_i && msw_ts && msw_mp && live;
    wire logic [1:0] n_exc = {1'h0, exc_req_i} + {1'h0, ts_fault} +
                             {1'h0, cop_fault};
    wire logic any_exc  = (n_exc != 2'h0);
    wire logic two_exc  = (n_exc > 2'h1);
    wire logic [7:0] ts_vec = ts_busy ? tsec_pkg::V_GP
                                      : tsec_pkg::V_TSS;
    wire logic [7:0] cand_vec = exc_req_i ? exc_vec_i :
                                ts_fault ? ts_vec : tsec_pkg::V_NOCOP;
    wire logic take_df  = any_exc && ((state == st_exc) ||
                          (state == st_run && two_exc));
    wire logic enter_shut = any_exc && (state == st_df);
    wire logic exc_go   = any_exc &&
                          (state == st_run || state == st_exc);
    wire logic [7:0] out_vec = take_df ? tsec_pkg::V_DF : cand_vec;

    tsec_pkg::tsec_exc_s next_exc;
    assign next_exc.vec         = out_vec;
    assign next_exc.err_push    = has_err(out_vec);
    assign next_exc.at_fault    = (out_vec != tsec_pkg::V_CSO);
    assign next_exc.restartable = !(stack_wrap_i && sp_wrapped(saved_sp_i))
        && out_vec != tsec_pkg::V_DF && out_vec != tsec_pkg::V_CSO
        && out_vec != tsec_pkg::V_GP;

    // Task switch side effects; coprocessor state is never touched
    tsec_pkg::tsec_ts_act_s next_act;
    assign next_act.mark_new    = 1'h1;
    assign next_act.mark_old    = !is_jmp;
    assign next_act.backlink_wr = 1'h1;
    assign next_act.old_sel     = tr_sel;

    // Flag updates, hardware events win over software writes
    wire logic next_ts = (ts_ok || interrupt_return_instruction_back) ? 1'h1 :
                         wr_msw ? reg_wdata_i[tsec_pkg::MSW_TS]
                                : msw_ts;
    wire logic next_nt = (ts_ok && !is_jmp) ? 1'h1 :
                         irq_nosw_i ? 1'h0 :
                         wr_flags ? reg_wdata_i[tsec_pkg::FLAG_NT]
                                  : flag_nt;
    wire logic next_pe = msw_pe ||
                         (wr_msw && reg_wdata_i[tsec_pkg::MSW_PE]);

    // Pointer tests
    wire logic [1:0] rpl_sel = ptest_i.sel[1:0];
    wire logic [1:0] rpl_ref = ptest_i.ref_val[1:0];
    wire logic privilege_adjust_instruction_chg = (rpl_ref > rpl_sel);
    wire logic lsl_ok   = ptest_i.priv_ok && ptest_i.type_ok;
    wire logic lar_ok   = ptest_i.priv_ok;
    wire logic next_zf  =
        (ptest_i.op == tsec_pkg::pt_privilege_adjust_instruction) ? privilege_adjust_instruction_chg :
        (ptest_i.op == tsec_pkg::pt_read_verify_instruction) ? ptest_i.rd_ok :
        (ptest_i.op == tsec_pkg::pt_write_verify_instruction) ? ptest_i.wr_ok :
        (ptest_i.op == tsec_pkg::pt_lsl)  ? lsl_ok : lar_ok;
    wire logic [15:0] next_pval =
        (ptest_i.op == tsec_pkg::pt_privilege_adjust_instruction) ?
            {ptest_i.sel[15:2], (privilege_adjust_instruction_chg ? rpl_ref : rpl_sel)} :
        (ptest_i.op == tsec_pkg::pt_lsl && lsl_ok) ? ptest_i.limit :
        (ptest_i.op == tsec_pkg::pt_lar && lar_ok) ?
            {ptest_i.access, 8'h00} : ptest_i.ref_val;

    // Boot address bits
    wire logic [3:0] next_a_hi =
        (seg_ref_i == tsec_pkg::seg_cs && !cs_changed && !msw_pe)
        ? tsec_pkg::A_HI_BOOT : tsec_pkg::A_HI_LOW;

    // Read data
    logic [15:0] next_rdata;
    always_comb begin
        case (reg_addr_i)
            tsec_pkg::REG_MSW:
                next_rdata = (16'(msw_pe) << tsec_pkg::MSW_PE) |
                             (16'(msw_mp) << tsec_pkg::MSW_MP) |
                             (16'(msw_ts) << tsec_pkg::MSW_TS);
            tsec_pkg::REG_FLAGS:
                next_rdata = 16'(flag_nt) << tsec_pkg::FLAG_NT;
            tsec_pkg::REG_TR_SEL:     next_rdata = tr_sel;
            tsec_pkg::REG_TR_BASE_LO: next_rdata = tr_base[15:0];
            tsec_pkg::REG_TR_BASE_HI: next_rdata = {8'h00, tr_base[23:16]};
            tsec_pkg::REG_TR_LIMIT:   next_rdata = tr_limit;
            tsec_pkg::REG_STATUS:
                next_rdata = (16'(state == st_shut) << tsec_pkg::STAT_SHUT) |
                             (16'(state == st_df) << tsec_pkg::STAT_DF) |
                             (16'(cs_changed) << tsec_pkg::STAT_CSCHG);
            default:                  next_rdata = 16'h0000;
        endcase
    end

    // Instruction exception sequencing
    always_comb begin
        next_state = state;
        case (state)
            st_run: begin
                if (any_exc) begin
                    next_state = two_exc ? st_df : st_exc;
                end
            end
            st_exc: begin
                if (any_exc) begin
                    next_state = st_df;
                end else if (instr_end_i) begin
                    next_state = st_run;
                end
            end
            st_df: begin
                if (any_exc) begin
                    next_state = st_shut;
                end else if (instr_end_i) begin
                    next_state = st_run;
                end
            end
            st_shut: begin
                if (nmi_i) begin
                    next_state = st_run;
                end
            end
            default: next_state = st_run;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            state      <= st_run;
            msw_pe     <= 1'h0;
            msw_mp     <= 1'h0;
            msw_ts     <= 1'h0;
            flag_nt    <= 1'h0;
            cs_changed <= 1'h0;
        end else begin
            state      <= next_state;
            msw_pe     <= next_pe;
            msw_mp     <= wr_msw ? reg_wdata_i[tsec_pkg::MSW_MP] : msw_mp;
            msw_ts     <= next_ts;
            flag_nt    <= next_nt;
            cs_changed <= cs_changed || cs_load_i;
        end
    end

    // Task selector and hidden copies
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            tr_sel   <= 16'h0000;
            tr_base  <= 24'h000000;
            tr_limit <= 16'h0000;
        end else if (ts_ok) begin
            tr_sel   <= ts_info_i.new_sel;
            tr_base  <= ts_info_i.new_base;
            tr_limit <= ts_info_i.new_limit;
        end else if (wr_tr) begin
            tr_sel   <= reg_wdata_i;
            tr_base  <= tr_desc_base_i;
            tr_limit <= tr_desc_limit_i;
        end
    end

    // Registered outputs
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            reg_rdata_o    <= 16'h0000;
            ts_act_valid_o <= 1'h0;
            ts_act_o       <= '0;
            interrupt_return_instruction_switch_o  <= 1'h0;
            interrupt_return_instruction_pop_o     <= 1'h0;
            exc_valid_o    <= 1'h0;
            exc_o          <= '0;
            running_o      <= 1'h1;
            halt_o         <= 1'h0;
            a1_o           <= 1'h1;
            ptest_done_o   <= 1'h0;
            ptest_zf_o     <= 1'h0;
            ptest_val_o    <= 16'h0000;
            a_hi_o         <= tsec_pkg::A_HI_BOOT;
            boot_cs_o      <= tsec_pkg::RESET_CS;
            boot_ip_o      <= tsec_pkg::RESET_IP;
        end else begin
            reg_rdata_o    <= reg_rd_i ? next_rdata : 16'h0000;
            ts_act_valid_o <= ts_ok;
            ts_act_o       <= ts_ok ? next_act : ts_act_o;
            interrupt_return_instruction_switch_o  <= interrupt_return_instruction_back;
            interrupt_return_instruction_pop_o     <= interrupt_return_instruction_pl;
            exc_valid_o    <= exc_go;
            exc_o          <= exc_go ? next_exc : exc_o;
            running_o      <= (next_state != st_shut);
            halt_o         <= enter_shut;
            a1_o           <= !enter_shut;
            ptest_done_o   <= ptest_req_i && live;
            ptest_zf_o     <= (ptest_req_i && live) ? next_zf : ptest_zf_o;
            ptest_val_o    <= (ptest_req_i && live) ? next_pval
                                                    : ptest_val_o;
            a_hi_o         <= next_a_hi;
        end
    end

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence first_fault_s;
        state == st_run && any_exc && !two_exc;
    endsequence
    sequence second_fault_s;
        any_exc;
    endsequence
    sequence df_entry_s;
        first_fault_s ##1 second_fault_s;
    endsequence

    ts_flag_set_a: assert property (ts_ok |=> msw_ts)
        else $error("task switch did not set task-switched flag");
    nt_set_a: assert property (ts_ok && !is_jmp |=> flag_nt)
        else $error("call or interrupt switch did not set nested flag");
    tr_load_a: assert property (ts_ok |=> tr_sel == $past(ts_info_i.new_sel)
        && tr_limit == $past(ts_info_i.new_limit))
        else $error("selector register or hidden limit not loaded");
    busy_old_a: assert property (ts_ok |=> ts_act_valid_o &&
        ts_act_o.mark_old == !$past(is_jmp))
        else $error("old segment busy marking wrong");
    busy_gp_a: assert property (ts_busy && !exc_req_i && !cop_fault &&
        state == st_run |=> exc_valid_o && exc_o.vec == 8'h0D)
        else $error("busy segment use did not give vector 13");
    interrupt_return_instruction_nest_a: assert property (interrupt_return_instruction_i && live |=>
        interrupt_return_instruction_switch_o == $past(flag_nt) && interrupt_return_instruction_pop_o != interrupt_return_instruction_switch_o)
        else $error("interrupt return took wrong path");
    cop_trap_a: assert property (cop_fault && !exc_req_i && !ts_fault &&
        state == st_run |=> exc_valid_o && exc_o.vec == 8'h07)
        else $error("coprocessor use did not give vector 7");
    err_code_a: assert property (exc_valid_o |-> exc_o.err_push ==
        (exc_o.vec == 8'h08 || (exc_o.vec >= 8'h0A && exc_o.vec <= 8'h0D))
        && exc_o.at_fault == (exc_o.vec != 8'h09))
        else $error("error code or return point wrong for vector");
    wrap_restart_a: assert property (exc_go && stack_wrap_i &&
        saved_sp_i == 16'hFFFF |=> !exc_o.restartable)
        else $error("wrapped stack reported restartable");
    double_fault_a: assert property (df_entry_s |=> exc_valid_o &&
        exc_o.vec == 8'h08)
        else $error("second exception did not give double fault");
    shut_halt_a: assert property (df_entry_s ##1 any_exc |=>
        halt_o && !a1_o && !running_o ##1 !halt_o)
        else $error("shutdown entry not announced by halt cycle");
    shut_quiet_a: assert property (!running_o |=>
        !exc_valid_o && !ts_act_valid_o && !ptest_done_o)
        else $error("activity during shutdown");
    verify_zf_a: assert property (ptest_req_i && live &&
        ptest_i.op == tsec_pkg::pt_write_verify_instruction |=> ptest_done_o &&
        ptest_zf_o == $past(ptest_i.wr_ok))
        else $error("write verify zero flag wrong");
    privilege_adjust_instruction_max_a: assert property (ptest_req_i && live &&
        ptest_i.op == tsec_pkg::pt_privilege_adjust_instruction |=> ptest_val_o[1:0] >=
        $past(ptest_i.ref_val[1:0]) && ptest_zf_o == ($past(ptest_i.
        ref_val[1:0]) > $past(ptest_i.sel[1:0])))
        else $error("privilege adjust result wrong");
    boot_addr_a: assert property (seg_ref_i == tsec_pkg::seg_cs &&
        !cs_changed && !msw_pe ##1 cs_load_i |=> a_hi_o == 4'hF)
        else $error("boot code fetch high bits not driven high");

endmodule // tsec_core

// File: shared/tsec_pkg.sv
// Constants and carrier types of the task switch and exception control core
package tsec_pkg;
    // Register indices on the plain register port
    localparam logic [3:0]  REG_MSW        = 4'h0;
    localparam logic [3:0]  REG_FLAGS      = 4'h1;
    localparam logic [3:0]  REG_TR_SEL     = 4'h2;
    localparam logic [3:0]  REG_TR_BASE_LO = 4'h3;
    localparam logic [3:0]  REG_TR_BASE_HI = 4'h4;
    localparam logic [3:0]  REG_TR_LIMIT   = 4'h5;
    localparam logic [3:0]  REG_STATUS     = 4'h6;
    // Field positions
    localparam int          MSW_PE         = 0;
    localparam int          MSW_MP         = 1;
    localparam int          MSW_TS         = 3;
    localparam int          FLAG_NT        = 14;
    localparam int          STAT_SHUT      = 0;
    localparam int          STAT_DF        = 1;
    localparam int          STAT_CSCHG     = 2;
    // Descriptor types and limits
    localparam logic [3:0]  TYPE_AVAIL     = 4'h1;
    localparam logic [3:0]  TYPE_BUSY      = 4'h3;
    localparam logic [15:0] TSS_MIN_LIMIT  = 16'h002B;
    // Exception vectors
    localparam logic [7:0]  V_NOCOP        = 8'h07;
    localparam logic [7:0]  V_DF           = 8'h08;
    localparam logic [7:0]  V_CSO          = 8'h09;
    localparam logic [7:0]  V_TSS          = 8'h0A;
    localparam logic [7:0]  V_NP           = 8'h0B;
    localparam logic [7:0]  V_SS           = 8'h0C;
    localparam logic [7:0]  V_GP           = 8'h0D;
    // Saved stack pointers that mark a wrapped push-all or pop-all
    localparam logic [15:0] SP_WRAP_0      = 16'h0000;
    localparam logic [15:0] SP_WRAP_1      = 16'h0001;
    localparam logic [15:0] SP_WRAP_2      = 16'hFFFE;
    localparam logic [15:0] SP_WRAP_3      = 16'hFFFF;
    // Reset fetch point and boot address bits
    localparam logic [15:0] RESET_CS       = 16'hF000;
    localparam logic [15:0] RESET_IP       = 16'hFFF0;
    localparam logic [3:0]  A_HI_BOOT      = 4'hF;
    localparam logic [3:0]  A_HI_LOW       = 4'h0;

    typedef enum logic [1:0] {
        src_jmp, src_call, src_int
    } tsec_src_e;

    typedef enum logic [2:0] {
        pt_privilege_adjust_instruction, pt_read_verify_instruction, pt_write_verify_instruction, pt_lsl, pt_lar
    } tsec_pt_e;

    typedef enum logic [1:0] {
        seg_cs, seg_ds, seg_es, seg_ss
    } tsec_seg_e;

    typedef struct packed {
        tsec_src_e   src;
        logic [15:0] new_sel;
        logic [3:0]  new_type;
        logic [23:0] new_base;
        logic [15:0] new_limit;
    } tsec_ts_req_s;

    typedef struct packed {
        logic        mark_new;
        logic        mark_old;
        logic        backlink_wr;
        logic [15:0] old_sel;
    } tsec_ts_act_s;

    typedef struct packed {
        tsec_pt_e    op;
        logic [15:0] sel;
        logic [15:0] ref_val;
        logic        rd_ok;
        logic        wr_ok;
        logic        priv_ok;
        logic        type_ok;
        logic [15:0] limit;
        logic [7:0]  access;
    } tsec_ptest_s;

    typedef struct packed {
        logic [7:0]  vec;
        logic        err_push;
        logic        at_fault;
        logic        restartable;
    } tsec_exc_s;
endpackage

// File: tb/tsec_sw_model.sv
// Software side model that forms task switch requests
`timescale 1ns/100ps
module tsec_sw_model (
    // Request choice
    input  wire tsec_pkg::tsec_src_e src_i,
    input  wire logic [15:0]         sel_i,
    input  wire logic                busy_i,
    input  wire logic                bad_lim_i,
    // Request to the core
    output tsec_pkg::tsec_ts_req_s   ts_info_o
);
    wire logic [3:0]  desc_type = busy_i ? tsec_pkg::TYPE_BUSY
                                         : tsec_pkg::TYPE_AVAIL;
    // Limit kept above the minimum unless told to break it
    wire logic [15:0] desc_lim  = tsec_pkg::TSS_MIN_LIMIT
                                  + {15'h0000, !bad_lim_i};
    assign ts_info_o = '{src_i, sel_i, desc_type, {8'h12, sel_i}, desc_lim};
endmodule // tsec_sw_model

// File: tb/tb.sv
// Self-checking bench of the task switch and exception control core
`timescale 1ns/100ps
module tb;
    localparam logic [7:0] P_PT = 8'h01, P_TS = 8'h02, P_INTERRUPT_RETURN_INSTRUCTION = 8'h04;
    localparam logic [7:0] P_NOSW = 8'h08, P_EXC = 8'h10, P_ESC = 8'h20;
    localparam logic [7:0] P_END = 8'h40, P_NMI = 8'h80;
    logic mclk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, cs_load_i = 0;
    logic stack_wrap_i = 0, busy = 0, bad = 0;
    logic nmi_i, instr_end_i, esc_i, exc_req_i, irq_nosw_i, interrupt_return_instruction_i;
    logic ts_req_i, ptest_req_i, ts_act_valid_o, interrupt_return_instruction_switch_o, interrupt_return_instruction_pop_o;
    logic exc_valid_o, running_o, halt_o, a1_o, ptest_done_o, ptest_zf_o;
    logic [7:0]  pl = 8'h00, exc_vec_i = 8'h00;
    logic [3:0]  reg_addr_i = 4'h0, a_hi_o;
    logic [15:0] reg_wdata_i = 16'h0000, saved_sp_i = 16'h0000, sel = 16'h0030;
    logic [15:0] tr_desc_limit_i = 16'h0100, reg_rdata_o, ptest_val_o;
    logic [15:0] boot_cs_o, boot_ip_o;
    logic [23:0] tr_desc_base_i = 24'h00ABCD;
    tsec_pkg::tsec_src_e    src = tsec_pkg::src_call;
    tsec_pkg::tsec_seg_e    seg_ref_i = tsec_pkg::seg_cs;
    tsec_pkg::tsec_ptest_s  ptest_i = '0;
    tsec_pkg::tsec_ts_req_s ts_info_i;
    tsec_pkg::tsec_ts_act_s ts_act_o;
    tsec_pkg::tsec_exc_s    exc_o;
    int n_errors = 0, checks = 0;
    assign {nmi_i, instr_end_i, esc_i, exc_req_i} = pl[7:4];
    assign {irq_nosw_i, interrupt_return_instruction_i, ts_req_i, ptest_req_i} = pl[3:0];
    tsec_core u_dut (.*);
    tsec_sw_model u_sw (.src_i(src), .sel_i(sel), .busy_i(busy),
                        .bad_lim_i(bad), .ts_info_o(ts_info_i));
    initial forever #5 mclk_i = ~mclk_i;
    task automatic chk(input logic [23:0] g, e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic fire(input logic [7:0] m);
        @(posedge mclk_i) pl <= m;
        @(posedge mclk_i) pl <= 8'h00;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk_i) {reg_rd_i, reg_addr_i} <= {1'h1, a};
        @(posedge mclk_i) reg_rd_i <= 0;
        #1 chk(reg_rdata_o, e);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'h1, a, d};
        @(posedge mclk_i) reg_wr_i <= 0;
    endtask
    task automatic t_boot();
        chk(boot_cs_o, 16'hF000);
        chk(boot_ip_o, 16'hFFF0);
        chk(a_hi_o, 4'hF);
        rd(tsec_pkg::REG_MSW, 16'h0000);
        @(posedge mclk_i) seg_ref_i <= tsec_pkg::seg_ds;
        @(posedge mclk_i) seg_ref_i <= tsec_pkg::seg_cs;
        #1 chk(a_hi_o, 4'h0);
        @(posedge mclk_i) cs_load_i <= 1;
        @(posedge mclk_i) cs_load_i <= 0;
        @(posedge mclk_i) #1 chk(a_hi_o, 4'h0);
    endtask
    task automatic t_switch();
        wr(tsec_pkg::REG_TR_SEL, 16'h0030);
        rd(tsec_pkg::REG_TR_BASE_LO, 16'hABCD);
        rd(tsec_pkg::REG_TR_LIMIT, 16'h0100);
        wr(tsec_pkg::REG_MSW, 16'h0002);
        fire(P_TS);
        chk(ts_act_valid_o, 1'h1);
        chk(ts_act_o, {3'h7, 16'h0030});
        rd(tsec_pkg::REG_TR_BASE_HI, 16'h0012);
        rd(tsec_pkg::REG_MSW, 16'h000A);
        rd(tsec_pkg::REG_FLAGS, 16'h4000);
        fire(P_INTERRUPT_RETURN_INSTRUCTION);
        chk(interrupt_return_instruction_switch_o, 1'h1);
        fire(P_NOSW);
        rd(tsec_pkg::REG_FLAGS, 16'h0000);
        fire(P_INTERRUPT_RETURN_INSTRUCTION);
        chk(interrupt_return_instruction_pop_o, 1'h1);
        @(posedge mclk_i) {src, sel} <= {tsec_pkg::src_jmp, 16'h0020};
        fire(P_TS);
        chk(ts_act_o, {3'h5, 16'h0030});
    endtask
    task automatic t_exc();
        @(posedge mclk_i) busy <= 1;
        fire(P_TS);
        chk(exc_o.vec, 8'h0D);
        @(posedge mclk_i) busy <= 0;
        fire(P_END);
        fire(P_ESC);
        chk(exc_o.vec, 8'h07);
        fire(P_END);
        wr(tsec_pkg::REG_MSW, 16'h0000);
        fire(P_ESC);
        chk(exc_valid_o, 1'h0);
        for (int v = 8; v < 14; v++) begin
            @(posedge mclk_i) exc_vec_i <= 8'(v);
            fire(P_EXC);
            chk(exc_o, {8'(v), {2{v != 9}}, !(v inside {8, 9, 13})});
            fire(P_END);
        end
        // Restartable vector so only the wrapped pointer can clear it
        @(posedge mclk_i) {stack_wrap_i, saved_sp_i, exc_vec_i} <=
            {1'h1, 16'hFFFE, 8'h0B};
        fire(P_EXC);
        chk(exc_o.restartable, 1'h0);
        fire(P_END);
        @(posedge mclk_i) stack_wrap_i <= 0;
    endtask
    task automatic pt(input tsec_pkg::tsec_pt_e op, input logic [15:0] s,
                      r, input logic ok, z, input logic [15:0] v);
        @(posedge mclk_i) ptest_i <= '{op, s, r, ok, ok, ok, ok,
                                       16'h0FFF, 8'h92};
        fire(P_PT);
        chk({ptest_done_o, ptest_zf_o, ptest_val_o}, {1'h1, z, v});
    endtask
    task automatic t_ptest();
        pt(tsec_pkg::pt_privilege_adjust_instruction, 16'h0011, 16'h0003, 0, 1, 16'h0013);
        pt(tsec_pkg::pt_privilege_adjust_instruction, 16'h0013, 16'h0001, 0, 0, 16'h0013);
        pt(tsec_pkg::pt_read_verify_instruction, 16'h0008, 16'h5555, 0, 0, 16'h5555);
        pt(tsec_pkg::pt_write_verify_instruction, 16'h0008, 16'h5555, 1, 1, 16'h5555);
        pt(tsec_pkg::pt_lsl, 16'h0008, 16'h5555, 1, 1, 16'h0FFF);
        pt(tsec_pkg::pt_lar, 16'h0008, 16'h5555, 1, 1, 16'h9200);
    endtask
    task automatic t_shut();
        wr(tsec_pkg::REG_MSW, 16'h0001);
        // Three faults on back-to-back edges: fault, double, shutdown
        @(posedge mclk_i) pl <= P_EXC;
        repeat (2) @(posedge mclk_i);
        @(posedge mclk_i) pl <= 8'h00;
        #1 chk(exc_o.vec, 8'h08);
        chk({halt_o, a1_o, running_o}, 3'h4);
        @(posedge mclk_i) #1 chk({halt_o, a1_o}, 2'h1);
        fire(P_TS);
        chk(ts_act_valid_o, 1'h0);
        fire(P_NMI);
        @(posedge mclk_i) #1 chk(running_o, 1'h1);
        rd(tsec_pkg::REG_MSW, 16'h0001);
        @(posedge mclk_i) rstn_i <= 0;
        @(posedge mclk_i) rstn_i <= 1;
        rd(tsec_pkg::REG_MSW, 16'h0000);
    endtask
    task automatic conclude();
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1;
        t_boot();
        t_switch();
        t_exc();
        t_ptest();
        t_shut();
        conclude();
    end
endmodule // tb
